// ==== rtl/plc_mode_ctrl.sv ====
// Operating mode, output hold, live program change and forcing control of a PLC CPU.
// Assumes a scan engine on the same clock streaming instruction flags and the
// program's output solution, and a classic Wishbone master for software.
//
// The Wishbone slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps

// What this block does
// - Leaving run for program clears all outputs.
// - Test-run to test-program holds or clears per output.
// - End instruction finishes the scan, skips rest.
// - Halt instruction enters program, outputs off.
// - Live change suspends scan, holds outputs.
// - Syntax error blocks return to run.
// - Deleted coil keeps output on until forced.
// - Inputs not sampled during live change.
// - Only editable instruction classes are accepted.
// - Force overwrites image bit through next refresh.
// - Forced point skips input and solution refresh.
// - Test indicator lit in either test mode.
// - Run indicator flashes during live change.
// - Timer and counter values kept in test-program.
// - Test-run runs set scans, up to 65525.
module plc_mode_ctrl
   import plc_mode_pkg::*;
#(
   parameter int BLINK_HALF_CYC_P = BLINK_HALF_CYC
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [NUM_IO-1:0] in_pins,
   output logic [NUM_IO-1:0] out_pins,
   output logic [NUM_IO-1:0] in_image,
   output logic scan_start,
   output logic exec_en,
   input wire logic instr_valid,
   input wire logic instr_end,
   input wire logic instr_halt,
   input wire logic [NUM_IO-1:0] sol_out,
   output logic tc_preserve,
   output logic test_led,
   output logic run_led
);

   function automatic logic scan_state(input op_state_e s);
      scan_state = (s == ST_RUN) || (s == ST_TEST_RUN);
   endfunction : scan_state

   function automatic logic test_state(input op_state_e s);
      test_state = (s == ST_TEST_RUN) || (s == ST_TEST_PROGRAM);
   endfunction : test_state

   function automatic op_state_e req_state(input logic [2:0] r);
      unique case (r)
         REQ_RUN: req_state = ST_RUN;
         REQ_TEST_PROGRAM: req_state = ST_TEST_PROGRAM;
         REQ_TEST_RUN: req_state = ST_TEST_RUN;
         REQ_LIVE_EDIT: req_state = ST_LIVE_EDIT;
         default: req_state = ST_PROGRAM;
      endcase
   endfunction : req_state

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      for (int b = 0; b < 4; b++) begin
         merge[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
      end
   endfunction : merge

   op_state_e state_q, state_d;
   logic wb_ack_q, wb_hit, wr;
   logic [31:0] wb_dat_q;
   logic mode_wr, edit_wr, force_wr, hold_wr, scans_wr;
   logic req_ok, halt_hit, end_hit, scans_done, go_program, test_hold, start_now;
   logic class_ok;
   logic [2:0] req;
   logic [IDX_W-1:0] fidx, eidx;
   logic fval, f_out;
   logic [NUM_IO-1:0] in_meta_q, in_sync_q, in_img_q, out_q, hold_q;
   logic [NUM_IO-1:0] out_force_q, in_force_q, keep_on_q, fsel;
   logic [15:0] scans_q, remain_q;
   logic [31:0] scans_m, hold_m;
   logic [EDIT_CNT_W-1:0] busy_q;
   logic in_scan_q, scan_start_q, syntax_err_q, edit_reject_q, refused_q;
   logic [BLINK_W-1:0] blink_cnt_q;
   logic blink_q, run_led_q, test_led_q, tc_preserve_q;

   assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_q;
   assign wr = wb_hit && wb_we_i && wb_sel_i[0];
   assign mode_wr = wr && (wb_adr_i == ADR_MODE);
   // editing only while live and idle
   assign edit_wr = wr && (wb_adr_i == ADR_EDIT) && (state_q == ST_LIVE_EDIT) && (busy_q == '0);
   assign force_wr = wr && (wb_adr_i == ADR_FORCE);
   assign hold_wr = wb_hit && wb_we_i && (wb_adr_i == ADR_HOLD);
   assign scans_wr = wb_hit && wb_we_i && (wb_adr_i == ADR_SCANS);
   assign req = wb_dat_i[2:0];
   assign fidx = wb_dat_i[IDX_W-1:0];
   assign fval = wb_dat_i[FORCE_VAL_BIT];
   assign f_out = wb_dat_i[FORCE_OUT_BIT];
   assign eidx = wb_dat_i[EDIT_IDX_LSB +: IDX_W];
   assign fsel = force_wr ? (NUM_IO'(1) << fidx) : '0;
   assign class_ok = wb_dat_i[5:0] <= EDIT_CLASS_LAST;
   assign scans_m = merge({16'h0000, scans_q}, wb_dat_i, wb_sel_i);
   assign hold_m = merge({16'h0000, hold_q}, wb_dat_i, wb_sel_i);

   assign end_hit = instr_valid && instr_end && in_scan_q;
   assign halt_hit = instr_valid && instr_halt && !instr_end && in_scan_q;
   assign scans_done = (state_q == ST_TEST_RUN) && end_hit && (remain_q == SCANS_MIN);

   always_comb begin
      state_d = state_q;
      req_ok = 1'b0;
      if (halt_hit) begin
         state_d = ST_PROGRAM;
      end else if (scans_done) begin
         state_d = ST_TEST_PROGRAM;
      end else if (mode_wr) begin
         unique case (state_q)
            ST_PROGRAM: req_ok = (req == REQ_RUN && !syntax_err_q) || req == REQ_TEST_PROGRAM;
            ST_RUN: req_ok = req == REQ_PROGRAM || req == REQ_TEST_RUN || req == REQ_LIVE_EDIT;
            ST_TEST_PROGRAM: req_ok = req == REQ_PROGRAM || req == REQ_TEST_RUN ||
                                      (req == REQ_RUN && !syntax_err_q);
            ST_TEST_RUN: req_ok = req == REQ_PROGRAM || req == REQ_RUN ||
                                  req == REQ_TEST_PROGRAM;
            // no return to run with a syntax error
            ST_LIVE_EDIT: req_ok = req == REQ_PROGRAM ||
                                   (req == REQ_RUN && busy_q == '0 && !syntax_err_q);
         endcase
         if (req_ok) begin
            state_d = req_state(req);
         end
      end
   end

   assign go_program = (state_d == ST_PROGRAM) && (state_q != ST_PROGRAM);
   assign test_hold = (state_q == ST_TEST_RUN) && (state_d == ST_TEST_PROGRAM);
   assign start_now = scan_state(state_q) && scan_state(state_d) && !in_scan_q;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= ST_PROGRAM;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         in_meta_q <= '0;
         in_sync_q <= '0;
      end else begin
         in_meta_q <= in_pins;
         in_sync_q <= in_meta_q;
      end
   end

   // scanning stops outside run states, so a live change suspends it.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         in_scan_q <= 1'b0;
         scan_start_q <= 1'b0;
      end else begin
         scan_start_q <= start_now;
         if (!scan_state(state_d) || end_hit) begin
            in_scan_q <= 1'b0;
         end else if (start_now) begin
            in_scan_q <= 1'b1;
         end
      end
   end

   // Output image. Halting, entry to program and the test-run hold take priority over the solution.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         out_q <= '0;
      end else if (go_program) begin
         out_q <= '0;
      end else if (test_hold) begin
         out_q <= out_q & hold_q;
      end else begin
         if (end_hit) begin
            out_q <= (sol_out & ~out_force_q) | (out_q & out_force_q) | keep_on_q;
         end
         if (force_wr && f_out) begin
            out_q[fidx] <= fval;
         end
      end
   end

   // force marks clear once the skipped refresh has passed
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         out_force_q <= '0;
         in_force_q <= '0;
      end else begin
         out_force_q <= ((end_hit || go_program) ? '0 : out_force_q) | (f_out ? fsel : '0);
         in_force_q <= (start_now ? '0 : in_force_q) | (f_out ? '0 : fsel);
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         in_img_q <= '0;
      end else begin
         // no input sampling while a live change runs
         if (start_now && state_q != ST_LIVE_EDIT) begin
            in_img_q <= (in_sync_q & ~in_force_q) | (in_img_q & in_force_q);
         end
         if (force_wr && !f_out) begin
            in_img_q[fidx] <= fval;
         end
      end
   end

   // deleted coil stays on until forced off
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         keep_on_q <= '0;
      end else if (go_program) begin
         keep_on_q <= '0;
      end else if (test_hold) begin
         // Outputs cleared by the hold mask drop their keep mark, so the mark never outlives its pin.
         keep_on_q <= keep_on_q & hold_q;
      end else if (edit_wr && class_ok && wb_dat_i[EDIT_DELETE_BIT] && out_q[eidx]) begin
         keep_on_q[eidx] <= 1'b1;
      end else if (force_wr && f_out && !fval) begin
         keep_on_q[fidx] <= 1'b0;
      end
   end

   // Live change apply timer and result flags.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         busy_q <= '0;
         syntax_err_q <= 1'b0;
         edit_reject_q <= 1'b0;
      end else begin
         if (edit_wr && class_ok) begin
            busy_q <= EDIT_CNT_W'(EDIT_APPLY_CYC);
         end else if (busy_q != '0) begin
            busy_q <= busy_q - EDIT_CNT_W'(1);
         end
         if (go_program) begin
            syntax_err_q <= 1'b0;
         end else if (edit_wr && class_ok) begin
            syntax_err_q <= wb_dat_i[EDIT_SYNTAX_BIT];
         end
         if (edit_wr) begin
            edit_reject_q <= !class_ok;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         scans_q <= SCANS_RESET;
         remain_q <= SCANS_RESET;
         hold_q <= HOLD_RESET;
         refused_q <= 1'b0;
      end else begin
         if (scans_wr) begin
            if (scans_m[15:0] > SCANS_MAX) begin
               scans_q <= SCANS_MAX;
            end else if (scans_m[15:0] < SCANS_MIN) begin
               scans_q <= SCANS_MIN;
            end else begin
               scans_q <= scans_m[15:0];
            end
         end
         if (state_d == ST_TEST_RUN && state_q != ST_TEST_RUN) begin
            remain_q <= scans_q;
         end else if (state_q == ST_TEST_RUN && end_hit) begin
            remain_q <= remain_q - 16'h0001;
         end
         if (hold_wr) begin
            hold_q <= hold_m[15:0];
         end
         if (mode_wr) begin
            refused_q <= !req_ok;
         end
      end
   end

   // Indicators. The blink divider runs always so the flash phase is free running.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         blink_cnt_q <= '0;
         blink_q <= 1'b0;
         run_led_q <= 1'b0;
         test_led_q <= 1'b0;
         tc_preserve_q <= 1'b0;
      end else begin
         if (blink_cnt_q == BLINK_W'(BLINK_HALF_CYC_P - 1)) begin
            blink_cnt_q <= '0;
            blink_q <= !blink_q;
         end else begin
            blink_cnt_q <= blink_cnt_q + BLINK_W'(1);
         end
         run_led_q <= (state_d == ST_LIVE_EDIT) ? blink_q : scan_state(state_d);
         test_led_q <= test_state(state_d);
         tc_preserve_q <= state_d == ST_TEST_PROGRAM;
      end
   end

   // Wishbone slave: one wait state, unmapped addresses read zero and are acked.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wb_ack_q <= 1'b0;
         wb_dat_q <= '0;
      end else begin
         wb_ack_q <= wb_hit;
         if (wb_hit) begin
            wb_dat_q <= '0;
            unique case (wb_adr_i)
               ADR_MODE: wb_dat_q[2:0] <= state_q;
               ADR_STATUS: begin
                  wb_dat_q[2:0] <= state_q;
                  wb_dat_q[STAT_REFUSED_BIT] <= refused_q;
                  wb_dat_q[STAT_SYNTAX_BIT] <= syntax_err_q;
                  wb_dat_q[STAT_REJECT_BIT] <= edit_reject_q;
                  wb_dat_q[STAT_BUSY_BIT] <= busy_q != '0;
                  wb_dat_q[STAT_TEST_BIT] <= test_led_q;
                  wb_dat_q[STAT_RUNLED_BIT] <= run_led_q;
               end
               ADR_HOLD: wb_dat_q[15:0] <= hold_q;
               ADR_SCANS: wb_dat_q[15:0] <= scans_q;
               ADR_OUT_IMG: wb_dat_q[15:0] <= out_q;
               ADR_IN_IMG: wb_dat_q[15:0] <= in_img_q;
               default: wb_dat_q <= '0;
            endcase
         end
      end
   end

   assign wb_ack_o = wb_ack_q;
   assign wb_dat_o = wb_dat_q;
   assign out_pins = out_q;
   assign in_image = in_img_q;
   assign scan_start = scan_start_q;
   assign exec_en = in_scan_q;
   assign tc_preserve = tc_preserve_q;
   assign test_led = test_led_q;
   assign run_led = run_led_q;

   property p_prog_off;
      @(posedge core_clk) disable iff (!rstn)
      go_program |=> (out_q == '0) && (state_q == ST_PROGRAM);
   endproperty
   a_prog_off: assert property (p_prog_off) else $error("outputs not cleared in program");

   property p_hold;
      @(posedge core_clk) disable iff (!rstn)
      test_hold |=> out_q == ($past(out_q) & $past(hold_q));
   endproperty
   a_hold: assert property (p_hold) else $error("hold mask not applied");

   property p_end;
      @(posedge core_clk) disable iff (!rstn)
      end_hit |=> !exec_en ##1 (scan_start || !scan_state(state_q) || !exec_en);
   endproperty
   a_end: assert property (p_end) else $error("execution continued past end");

   property p_halt;
      @(posedge core_clk) disable iff (!rstn)
      halt_hit |=> state_q == ST_PROGRAM && out_pins == '0;
   endproperty
   a_halt: assert property (p_halt) else $error("halt did not stop");

   property p_edit_freeze;
      @(posedge core_clk) disable iff (!rstn)
      (state_q == ST_LIVE_EDIT && !force_wr && !go_program) |=> $stable(out_q) && !exec_en;
   endproperty
   a_edit_freeze: assert property (p_edit_freeze) else $error("outputs moved in edit");

   property p_syntax;
      @(posedge core_clk) disable iff (!rstn)
      (state_q == ST_LIVE_EDIT && syntax_err_q) |=> state_q != ST_RUN;
   endproperty
   a_syntax: assert property (p_syntax) else $error("run entered with syntax error");

   property p_keep;
      @(posedge core_clk) disable iff (!rstn)
      (keep_on_q != '0) |-> (out_q & keep_on_q) == keep_on_q;
   endproperty
   a_keep: assert property (p_keep) else $error("kept output dropped");

   property p_no_input;
      @(posedge core_clk) disable iff (!rstn)
      (state_q == ST_LIVE_EDIT && !force_wr) |=> $stable(in_img_q);
   endproperty
   a_no_input: assert property (p_no_input) else $error("input sampled in edit");

   property p_reject;
      @(posedge core_clk) disable iff (!rstn)
      (edit_wr && !class_ok) |=> edit_reject_q && busy_q == '0;
   endproperty
   a_reject: assert property (p_reject) else $error("bad class accepted");

   property p_force;
      @(posedge core_clk) disable iff (!rstn)
      (force_wr && !f_out) |=> in_img_q[$past(fidx)] == $past(fval) && in_force_q[$past(fidx)];
   endproperty
   a_force: assert property (p_force) else $error("force not applied");

   property p_test_led;
      @(posedge core_clk) disable iff (!rstn)
      test_state(state_q) |-> test_led;
   endproperty
   a_test_led: assert property (p_test_led) else $error("test indicator dark");

   property p_scans;
      @(posedge core_clk) disable iff (!rstn)
      scans_done |=> state_q == ST_TEST_PROGRAM && tc_preserve;
   endproperty
   a_scans: assert property (p_scans) else $error("scan count not honoured");

endmodule : plc_mode_ctrl

// ==== rtl/plc_mode_pkg.sv ====
// Constants, register map and state type for the PLC mode and output hold controller.
// Assumes a 25 MHz core clock and a 32-bit classic Wishbone register bus.
package plc_mode_pkg;
   localparam int NUM_IO = 16;
   localparam int IDX_W = 4;

   typedef enum logic [2:0] {
      ST_PROGRAM,
      ST_RUN,
      ST_TEST_PROGRAM,
      ST_TEST_RUN,
      ST_LIVE_EDIT
   } op_state_e;

   // Mode request codes written to the mode register.
   localparam logic [2:0] REQ_PROGRAM = 3'h0;
   localparam logic [2:0] REQ_RUN = 3'h1;
   localparam logic [2:0] REQ_TEST_PROGRAM = 3'h2;
   localparam logic [2:0] REQ_TEST_RUN = 3'h3;
   localparam logic [2:0] REQ_LIVE_EDIT = 3'h4;

   // Byte addresses of the registers.
   localparam logic [4:0] ADR_MODE = 5'h00;
   localparam logic [4:0] ADR_STATUS = 5'h04;
   localparam logic [4:0] ADR_HOLD = 5'h08;
   localparam logic [4:0] ADR_SCANS = 5'h0c;
   localparam logic [4:0] ADR_EDIT = 5'h10;
   localparam logic [4:0] ADR_FORCE = 5'h14;
   localparam logic [4:0] ADR_OUT_IMG = 5'h18;
   localparam logic [4:0] ADR_IN_IMG = 5'h1c;

   // Field positions.
   localparam int EDIT_SYNTAX_BIT = 8;
   localparam int EDIT_DELETE_BIT = 9;
   localparam int EDIT_IDX_LSB = 16;
   localparam int FORCE_VAL_BIT = 8;
   localparam int FORCE_OUT_BIT = 15;
   localparam int STAT_REFUSED_BIT = 4;
   localparam int STAT_SYNTAX_BIT = 5;
   localparam int STAT_REJECT_BIT = 6;
   localparam int STAT_BUSY_BIT = 7;
   localparam int STAT_TEST_BIT = 8;
   localparam int STAT_RUNLED_BIT = 9;

   localparam logic [5:0] EDIT_CLASS_LAST = 6'h1e;
   localparam logic [15:0] SCANS_MIN = 16'h0001;
   localparam logic [15:0] SCANS_MAX = 16'hfff5;
   localparam logic [15:0] SCANS_RESET = 16'h0001;
   localparam logic [15:0] HOLD_RESET = 16'h0000;

   // Timing.
   localparam int CLK_PERIOD_NS = 40;
   localparam int EDIT_APPLY_NS = 1000;
   localparam int EDIT_APPLY_CYC = (EDIT_APPLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int EDIT_CNT_W = 5;
   localparam int BLINK_HALF_MS = 250;
   localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
   localparam int BLINK_W = 23;
endpackage : plc_mode_pkg

// ==== tb/plc_mode_ctrl_tb.sv ====
// Self-checking bench for the PLC mode controller, driven over classic Wishbone.
// Assumes the scan engine stand-in on the far side and a 25 MHz core clock.
`timescale 1ns/100ps
module plc_mode_ctrl_tb
   import plc_mode_pkg::*;
;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [4:0] wb_adr = 5'h00;
   logic [3:0] wb_sel = 4'hf;
   logic [31:0] wb_dat = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic [NUM_IO-1:0] in_pins = 16'h0000;
   logic [NUM_IO-1:0] sol_val = 16'h0000;
   logic [NUM_IO-1:0] out_pins, in_image, sol_out;
   logic [3:0] lat = 4'h0;
   logic halt_req = 1'b0;
   logic trail_halt = 1'b0;
   logic scan_start, exec_en, instr_valid, instr_end, instr_halt, tc_preserve, test_led, run_led;
   logic r0;
   int mismatches = 0;
   int checks = 0;
   int n_scan = 0;
   int s0 = 0;

   plc_mode_ctrl #(.BLINK_HALF_CYC_P(4)) i_dut (
      .core_clk, .rstn, .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o, .wb_ack_o,
      .in_pins, .out_pins, .in_image, .scan_start, .exec_en, .instr_valid, .instr_end,
      .instr_halt, .sol_out, .tc_preserve, .test_led, .run_led);

   scan_engine_model i_eng (
      .core_clk, .rstn, .scan_start, .exec_en, .sol_val, .lat, .halt_req, .trail_halt,
      .instr_valid, .instr_end, .instr_halt, .sol_out);

   initial begin
      forever begin
         #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
      end
   end

   always @(posedge core_clk) begin
      if (scan_start === 1'b1) begin
         n_scan++;
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // The request is held until ack is sampled high; release follows that same edge.
   task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] dat,
                     output logic [31:0] q);
      int n;
      n = 0;
      @(posedge core_clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_dat <= dat;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 64);
      q = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      if (n >= 64) chk("wb_ack", 32'h1, 32'h0);
   endtask : wb

   task automatic rd(input logic [4:0] adr, input logic [31:0] mask, input logic [31:0] exp,
                     input string what);
      logic [31:0] q;
      wb(1'b0, adr, 32'h0, q);
      chk(what, exp, q & mask);
   endtask : rd

   task automatic wr(input logic [4:0] adr, input logic [31:0] dat);
      logic [31:0] q;
      wb(1'b1, adr, dat, q);
   endtask : wr

   task automatic md(input logic [2:0] code);
      wr(ADR_MODE, {29'h0, code});
   endtask : md

   task automatic st(input logic [2:0] code);
      logic [31:0] q;
      int i;
      i = 0;
      do begin
         wb(1'b0, ADR_MODE, 32'h0, q);
         i++;
      end while (q[2:0] !== code && i < 100);
      chk("state", {29'h0, code}, q);
   endtask : st

   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
   endtask : idle

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : summarize

   initial begin
      #(CLK_PERIOD_NS * 20000);
      mismatches++;
      summarize();
   end

   initial begin
      repeat (12) @(posedge core_clk);
      rstn <= 1'b1;
      rd(ADR_MODE, 32'hffffffff, 32'h0, "mode"); // reset state
      rd(ADR_STATUS, 32'hffffffff, 32'h0, "status"); // leds off
      rd(ADR_HOLD, 32'hffffffff, 32'h0, "hold");
      rd(ADR_SCANS, 32'hffffffff, 32'h1, "scans"); // reset count
      rd(5'h02, 32'hffffffff, 32'h0, "unmapped");
      md(REQ_LIVE_EDIT);
      rd(ADR_STATUS, 32'h17, 32'h10, "refused"); // illegal request
      sol_val <= 16'ha5c3;
      trail_halt <= 1'b1;
      md(REQ_RUN);
      idle(20);
      chk("out", 32'ha5c3, {16'h0, out_pins}); // solution applied
      rd(ADR_MODE, 32'h7, 32'h1, "mode"); // stray halt ignored
      chk("leds", 32'h1, {30'h0, test_led, run_led}); // run solid
      trail_halt <= 1'b0;
      md(REQ_PROGRAM);
      idle(2);
      chk("out", 32'h0, {16'h0, out_pins}); // outputs off
      wr(ADR_SCANS, 32'h0);
      rd(ADR_SCANS, 32'hffff, 32'h1, "scans"); // lower clamp
      wr(ADR_SCANS, 32'hffff);
      rd(ADR_SCANS, 32'hffff, 32'hfff5, "scans"); // upper clamp
      wr(ADR_SCANS, 32'h3);
      wr(ADR_HOLD, 32'h00ff);
      rd(ADR_HOLD, 32'hffff, 32'h00ff, "hold"); // mask stored
      md(REQ_TEST_PROGRAM);
      idle(2);
      chk("tp", 32'h6, {29'h0, tc_preserve, test_led, run_led}); // test program
      sol_val <= 16'hffff;
      lat <= 4'h2;
      s0 = n_scan;
      md(REQ_TEST_RUN);
      st(REQ_TEST_PROGRAM); // auto return
      chk("n_scan", 32'h3, n_scan - s0); // scan count
      chk("out", 32'h00ff, {16'h0, out_pins}); // hold or clear
      chk("tp", 32'h6, {29'h0, tc_preserve, test_led, run_led}); // values kept
      md(REQ_PROGRAM);
      lat <= 4'h9;
      md(REQ_RUN);
      idle(40);
      chk("out", 32'hffff, {16'h0, out_pins});
      halt_req <= 1'b1;
      st(REQ_PROGRAM); // halt to program
      chk("out", 32'h0, {16'h0, out_pins}); // outputs off
      chk("exec_en", 32'h0, {31'h0, exec_en}); // execution stopped
      halt_req <= 1'b0;
      sol_val <= 16'h0f0f;
      lat <= 4'h1;
      md(REQ_RUN);
      idle(20);
      md(REQ_LIVE_EDIT);
      rd(ADR_MODE, 32'h7, 32'h4, "mode"); // edit entered
      r0 = run_led;
      idle(4);
      chk("run_led", {31'h0, ~r0}, {31'h0, run_led}); // flashing
      sol_val <= 16'h0000;
      in_pins <= 16'h0055;
      idle(20);
      chk("out", 32'h0f0f, {16'h0, out_pins}); // outputs held
      chk("exec_en", 32'h0, {31'h0, exec_en}); // scan suspended
      rd(ADR_IN_IMG, 32'hffff, 32'h0, "in_img"); // inputs ignored
      wr(ADR_EDIT, 32'h1f);
      rd(ADR_STATUS, 32'h40, 32'h40, "reject"); // class refused
      wr(ADR_EDIT, 32'h0201);
      rd(ADR_STATUS, 32'hc0, 32'h80, "busy"); // edit applying
      idle(30);
      md(REQ_RUN);
      idle(20);
      chk("out", 32'h0001, {16'h0, out_pins}); // deleted coil kept
      rd(ADR_IN_IMG, 32'hffff, 32'h0055, "in_img"); // sampling resumed
      wr(ADR_FORCE, 32'h8000);
      idle(20);
      chk("out", 32'h0, {16'h0, out_pins}); // forced off
      md(REQ_LIVE_EDIT);
      wr(ADR_EDIT, 32'h0102);
      idle(30);
      md(REQ_RUN);
      rd(ADR_STATUS, 32'h37, 32'h34, "syntax"); // run refused
      md(REQ_PROGRAM);
      wr(ADR_FORCE, 32'h0103);
      rd(ADR_IN_IMG, 32'hffff, 32'h005d, "in_img"); // input forced
      chk("in_image", 32'h005d, {16'h0, in_image}); // image port
      md(REQ_RUN);
      idle(30);
      rd(ADR_IN_IMG, 32'hffff, 32'h0055, "in_img"); // force expired
      md(REQ_PROGRAM);
      summarize();
   end
endmodule : plc_mode_ctrl_tb

// ==== tb/scan_engine_model.sv ====
// Scan engine stand-in: answers each scan with one end or one halt instruction, plus a stray halt after the end when trail_halt is set.
// Assumes the controller's scan_start pulse and exec_en level on the same clock.
`timescale 1ns/100ps
module scan_engine_model
   import plc_mode_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic scan_start,
   input wire logic exec_en,
   input wire logic [NUM_IO-1:0] sol_val,
   input wire logic [3:0] lat,
   input wire logic halt_req,
   input wire logic trail_halt,
   output logic instr_valid,
   output logic instr_end,
   output logic instr_halt,
   output logic [NUM_IO-1:0] sol_out
);
   logic [3:0] cnt_q;
   logic busy_q;

   // The solution lines change every cycle outside the end cycle, so a stale sample shows up.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 4'h0;
         busy_q <= 1'b0;
         instr_valid <= 1'b0;
         instr_end <= 1'b0;
         instr_halt <= 1'b0;
         sol_out <= 16'h0000;
      end else begin
         instr_valid <= 1'b0;
         instr_end <= 1'b0;
         instr_halt <= 1'b0;
         sol_out <= ~sol_out;
         if (scan_start) begin
            cnt_q <= lat;
            busy_q <= 1'b1;
         end else if (busy_q && exec_en) begin
            if (cnt_q == 4'h0) begin
               busy_q <= 1'b0;
               instr_valid <= 1'b1;
               instr_halt <= halt_req;
               instr_end <= ~halt_req;
               if (!halt_req) begin
                  sol_out <= sol_val;
               end
            end else begin
               cnt_q <= cnt_q - 4'h1;
            end
         end else if (instr_end && trail_halt) begin
            // A stray halt placed after the end instruction, sent while exec_en is low.
            instr_valid <= 1'b1;
            instr_halt <= 1'b1;
         end
      end
   end
endmodule : scan_engine_model
